// File: otpm_pkg.sv
// Shared constants and types for the memory manual command and status block.
// Assumes a 20 MHz system clock and a simple internal register port.
package otpm_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned CLK_MHZ          = 20;
  localparam int unsigned MON_PERIOD_US    = 1024;
  localparam int unsigned MON_TICK_CYCLES  = MON_PERIOD_US * CLK_MHZ;
  // Phase times of the macro sequence, least times, rounded up to cycles
  localparam int unsigned PWRUP_SETTLE_NS  = 1000;
  localparam int unsigned RESET_SETTLE_NS  = 500;
  localparam int unsigned SETUP_NS         = 100;
  localparam int unsigned PULSE_NS         = 1000;
  localparam int unsigned HOLD_NS          = 100;
  localparam int unsigned RECOVERY_NS      = 200;
  localparam int unsigned PWRUP_SETTLE_CYC =
    (PWRUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_SETTLE_CYC =
    (RESET_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC        =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC        =
    (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC         =
    (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_CYC     =
    (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] LAUNCH_OFS = 4'h0;
  localparam logic [3:0] LIMIT_OFS  = 4'h1;
  localparam logic [3:0] EVENT_OFS  = 4'h2;
  localparam logic [3:0] STATUS_OFS = 4'h3;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned LAUNCH_BIT     = 0;
  localparam int unsigned LIMIT_W        = 14;
  localparam logic [13:0] LIMIT_RST      = 14'h03d0;
  localparam int unsigned EV_DONE_BIT    = 7;
  localparam int unsigned EV_STATUS_BIT  = 6;
  localparam int unsigned EV_PUMP_BIT    = 5;
  localparam int unsigned EV_ASSIST_BIT  = 3;
  localparam int unsigned EV_EMPTY_BIT   = 2;
  localparam int unsigned EV_BOOT_BIT    = 1;
  localparam int unsigned EV_CRC_BIT     = 0;
  localparam logic [7:0]  EVENT_RST      = 8'h00;
  localparam int unsigned ST_BUSY_BIT    = 7;
  localparam int unsigned ST_STATUS_BIT  = 6;
  localparam int unsigned ST_PUMP_BIT    = 5;
  localparam int unsigned ST_PWRUP_BIT   = 4;

  // ----------------------------------------------------------------------
  // Controller state codes as shown in the status register
  // ----------------------------------------------------------------------
  localparam logic [2:0] CODE_RESET    = 3'h0;
  localparam logic [2:0] CODE_PWRUP    = 3'h1;
  localparam logic [2:0] CODE_RSTSET   = 3'h2;
  localparam logic [2:0] CODE_IDLE     = 3'h4;
  localparam logic [2:0] CODE_SETUP    = 3'h5;
  localparam logic [2:0] CODE_PULSE    = 3'h7;
  localparam logic [2:0] CODE_HOLD     = 3'h3;
  localparam logic [2:0] CODE_RECOVERY = 3'h6;

  typedef enum logic [2:0] {
    ST_RESET, ST_POWERUP_SETTLE, ST_RESET_SETTLE, ST_IDLE,
    ST_SETUP, ST_PULSE, ST_HOLD, ST_RECOVERY
  } otpm_state_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic macroStatus;
    logic pumpMonitorSignal;
    logic macroPowerUp;
  } otpm_pins_t;

  typedef struct packed {
    logic assistFail;
    logic configEmpty;
    logic bootLoadFail;
    logic bootCrcError;
  } otpm_events_t;

  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [15:0] wdata;
  } otpm_regreq_t;

endpackage

// File: otpm_manual_command_status.sv
// Manual command launch, pump timeout monitor, sticky events and status
// of the one-time-programmable memory controller.
// Assumes the serial port core issues single-cycle register requests on
// clk, and that the macro pins arrive unsynchronised.
`timescale 1ns/1ps

// Notes on behaviour
// - Writing launch one starts manual command
// - Launch bit always reads back zero
// - Access lock blocks a launch from idle; a command already running completes
// - Limit counts 1024 us monitor periods
// - Limit resets to default 0x3d0
// - Done flag bit 7 on completion
// - Bit 6 latches high macro status
// - Bit 5 set on pump timeout
// - Pump error uncleared while condition stays
// - Bit 3 set on assist failure
// - Bit 2 set on empty image load
// - Bit 1 set on boot load failure
// - Bit 0 set on boot CRC error
// - Event flags clear by writing one
// - Busy bit 7 high during request
// - Bits 6..4 show live macro pins
// - State code follows fixed encoding
module otpm_manual_command_status #(
  parameter int unsigned MonTickCycles = otpm_pkg::MON_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Register port
  input  wire otpm_pkg::otpm_regreq_t  regReq,
  output      logic [15:0]             regRdata_r,
  // Macro pins and lock
  input  wire otpm_pkg::otpm_pins_t    macroPins,
  input  wire logic                    accessLock,
  // Events from loader and command datapath
  input  wire otpm_pkg::otpm_events_t  events,
  // Sequence outputs
  output      logic                    cmdStart_r,
  output      logic                    macroPulse_r,
  output      logic                    manualBusy_r
);
  import otpm_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hitReg(input otpm_regreq_t r,
                                  input logic [3:0] ofs);
    hitReg = (r.addr == ofs);
  endfunction

  function automatic logic [2:0] stateCode(input otpm_state_t s);
    case (s)
      ST_RESET:          stateCode = CODE_RESET;
      ST_POWERUP_SETTLE: stateCode = CODE_PWRUP;
      ST_RESET_SETTLE:   stateCode = CODE_RSTSET;
      ST_IDLE:           stateCode = CODE_IDLE;
      ST_SETUP:          stateCode = CODE_SETUP;
      ST_PULSE:          stateCode = CODE_PULSE;
      ST_HOLD:           stateCode = CODE_HOLD;
      ST_RECOVERY:       stateCode = CODE_RECOVERY;
      default:           stateCode = CODE_RESET;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // A level is accepted only when the second and third stages agree.
  logic [2:0] pinRaw;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] pinLevel_r;

  assign pinRaw = macroPins;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          sync1_r[gi]    <= 1'b0;
          sync2_r[gi]    <= 1'b0;
          sync3_r[gi]    <= 1'b0;
          pinLevel_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pinRaw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            pinLevel_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  logic statusLvl;
  logic pumpLvl;
  logic pwrUpLvl;
  assign statusLvl = pinLevel_r[2];
  assign pumpLvl   = pinLevel_r[1];
  assign pwrUpLvl  = pinLevel_r[0];

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // A launch write with bit 0 clear is a no-op
  logic launchWr;
  logic eventWr;
  assign launchWr = regReq.wr && hitReg(regReq, LAUNCH_OFS) &&
                    regReq.wdata[LAUNCH_BIT];
  assign eventWr  = regReq.wr && hitReg(regReq, EVENT_OFS);

  // limit register
  // Bits 15:14 of a limit write are dropped
  logic [LIMIT_W-1:0] limit_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      limit_r <= LIMIT_RST;
    end else if (regReq.wr && hitReg(regReq, LIMIT_OFS)) begin
      limit_r <= regReq.wdata[LIMIT_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Controller sequence
  // ----------------------------------------------------------------------
  otpm_state_t state_r;
  otpm_state_t state_nxt;
  logic [15:0] phaseCnt_r;
  logic        phaseEnd;
  logic [15:0] phaseLen;

  // Phase lengths are least times, so rounding only lengthens them
  always_comb begin
    case (state_r)
      ST_POWERUP_SETTLE: phaseLen = 16'(PWRUP_SETTLE_CYC);
      ST_RESET_SETTLE:   phaseLen = 16'(RESET_SETTLE_CYC);
      ST_SETUP:          phaseLen = 16'(SETUP_CYC);
      ST_PULSE:          phaseLen = 16'(PULSE_CYC);
      ST_HOLD:           phaseLen = 16'(HOLD_CYC);
      ST_RECOVERY:       phaseLen = 16'(RECOVERY_CYC);
      default:           phaseLen = 16'h0001;
    endcase
  end
  assign phaseEnd = (phaseCnt_r + 16'h0001 >= phaseLen);

  // Start-up states hold off launches until the macro reports power-up and both settle times have run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:          state_nxt = ST_POWERUP_SETTLE;
      ST_POWERUP_SETTLE: if (phaseEnd && pwrUpLvl) begin
        state_nxt = ST_RESET_SETTLE;
      end
      ST_RESET_SETTLE:   if (phaseEnd) begin
        state_nxt = ST_IDLE;
      end
      // launch only from idle and unlocked
      ST_IDLE:           if (launchWr && !accessLock) begin
        state_nxt = ST_SETUP;
      end
      ST_SETUP:          if (phaseEnd) begin
        state_nxt = ST_PULSE;
      end
      ST_PULSE:          if (phaseEnd) begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD:           if (phaseEnd) begin
        state_nxt = ST_RECOVERY;
      end
      ST_RECOVERY:       if (phaseEnd) begin
        state_nxt = ST_IDLE;
      end
      default:           state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Each phase restarts its count, so phase times never carry over
  always_ff @(posedge clk) begin
    if (reset) begin
      phaseCnt_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      phaseCnt_r <= 16'h0000;
    end else if (!phaseEnd) begin
      phaseCnt_r <= phaseCnt_r + 16'h0001;
    end
  end

  logic doneEvt;
  assign doneEvt = (state_r == ST_RECOVERY) && (state_nxt == ST_IDLE);

  always_ff @(posedge clk) begin
    if (reset) begin
      manualBusy_r <= 1'b0;
    end else begin
      manualBusy_r <= (state_nxt == ST_SETUP) || (state_nxt == ST_PULSE) ||
                      (state_nxt == ST_HOLD) || (state_nxt == ST_RECOVERY);
    end
  end

  // Start strobe is one cycle wide, taken only on the idle exit
  always_ff @(posedge clk) begin
    if (reset) begin
      cmdStart_r <= 1'b0;
    end else begin
      cmdStart_r <= (state_r == ST_IDLE) && (state_nxt == ST_SETUP);
    end
  end

  // Pulse output is taken from the next state so it lines up with it
  always_ff @(posedge clk) begin
    if (reset) begin
      macroPulse_r <= 1'b0;
    end else begin
      macroPulse_r <= (state_nxt == ST_PULSE);
    end
  end

  // ----------------------------------------------------------------------
  // Pump timeout monitor
  // ----------------------------------------------------------------------
  // The tick divider is long, so it is a parameter for short simulations.
  logic [31:0]        tickCnt_r;
  logic [LIMIT_W:0]   periods_r;
  logic               tickEnd;
  logic               pumpTimeout;

  assign tickEnd = (tickCnt_r + 32'h0000_0001 >= 32'(MonTickCycles));

  // Both counters restart whenever the pump leaves its idle condition
  always_ff @(posedge clk) begin
    if (reset || !pumpLvl) begin
      tickCnt_r <= 32'h0000_0000;
    end else if (tickEnd) begin
      tickCnt_r <= 32'h0000_0000;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !pumpLvl) begin
      periods_r <= '0;
    end else if (tickEnd && !periods_r[LIMIT_W]) begin
      periods_r <= periods_r + (LIMIT_W+1)'(1);
    end
  end

  // timeout when idle periods exceed limit
  assign pumpTimeout = pumpLvl && (periods_r > {1'b0, limit_r});

  // ----------------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------------
  logic [7:0] event_r;
  logic [7:0] eventSet;
  logic [7:0] eventClr;

  always_comb begin
    eventSet = 8'h00;
    eventSet[EV_DONE_BIT]   = doneEvt;
    eventSet[EV_STATUS_BIT] = statusLvl;
    eventSet[EV_PUMP_BIT]   = pumpTimeout;
    eventSet[EV_ASSIST_BIT] = events.assistFail;
    eventSet[EV_EMPTY_BIT]  = events.configEmpty;
    eventSet[EV_BOOT_BIT]   = events.bootLoadFail;
    eventSet[EV_CRC_BIT]    = events.bootCrcError;
  end

  assign eventClr = eventWr ? regReq.wdata[7:0] : 8'h00;

  // Bit 4 is reserved and always reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      event_r <= EVENT_RST;
    end else begin
      event_r <= ((event_r & ~eventClr) | eventSet) & 8'hef;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  // Pins are seen through the synchronisers, so reads lag them
  logic [7:0] statusWord;
  always_comb begin
    statusWord = 8'h00;
    statusWord[ST_BUSY_BIT]   = manualBusy_r;
    statusWord[ST_STATUS_BIT] = statusLvl;
    statusWord[ST_PUMP_BIT]   = pumpLvl;
    statusWord[ST_PWRUP_BIT]  = pwrUpLvl;
    statusWord[2:0]           = stateCode(state_r);
  end

  // Unmapped indices and reserved bits read back as zero
  logic [15:0] readWord;
  always_comb begin
    readWord = 16'h0000;
    if (hitReg(regReq, LAUNCH_OFS)) begin
      readWord = 16'h0000;
    end else if (hitReg(regReq, LIMIT_OFS)) begin
      readWord = {2'b00, limit_r};
    end else if (hitReg(regReq, EVENT_OFS)) begin
      readWord = {8'h00, event_r};
    end else if (hitReg(regReq, STATUS_OFS)) begin
      readWord = {8'h00, statusWord};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regRdata_r <= 16'h0000;
    end else if (regReq.rd) begin
      regRdata_r <= readWord;
    end
  end

endmodule

// File: otpm_macro_model.sv
// Behavioural memory macro facing the command and status block.
// Assumes the bench steers the status and pump monitor levels.
`timescale 1ns/1ps
module otpm_macro_model #(
  parameter int unsigned PwrUpDelay = 6
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Bench steering
  input  wire logic                 statusReq,
  input  wire logic                 pumpIdleReq,
  // Macro pins
  output      otpm_pkg::otpm_pins_t macroPins
);
  import otpm_pkg::*;
  int unsigned pwrCnt_r;
  // Power-up rises 6 cycles after reset, inside the 20-cycle power-up settle, so the settle time alone sets the start-up wait
  always_ff @(posedge clk) begin
    if (reset) pwrCnt_r <= 0;
    else if (pwrCnt_r < PwrUpDelay) pwrCnt_r <= pwrCnt_r + 1;
  end
  // One driver for the whole carrier: status, pump monitor, power-up
  assign macroPins = {statusReq, pumpIdleReq, (pwrCnt_r == PwrUpDelay)};
endmodule

// File: otpm_manual_command_status_props.sv
// Port-level checker for the manual command and status block.
// Assumes single-cycle register strobes and the package phase times.
`timescale 1ns/1ps
module otpm_manual_command_status_props
  import otpm_pkg::*;
#(
  parameter int unsigned MonTickCycles = otpm_pkg::MON_TICK_CYCLES
) (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire otpm_pkg::otpm_regreq_t regReq,
  input wire logic [15:0]            regRdata_r,
  input wire otpm_pkg::otpm_pins_t   macroPins,
  input wire logic                   accessLock,
  input wire otpm_pkg::otpm_events_t events,
  input wire logic                   cmdStart_r,
  input wire logic                   macroPulse_r,
  input wire logic                   manualBusy_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic launchWr;
  logic launchRd;
  logic statusRd;
  assign launchWr = regReq.wr && regReq.addr == LAUNCH_OFS && regReq.wdata[0];
  assign launchRd = regReq.rd && regReq.addr == LAUNCH_OFS;
  assign statusRd = regReq.rd && regReq.addr == STATUS_OFS;

  a_start_busy: assert property ($rose(manualBusy_r) |-> cmdStart_r)
    else $error("busy rose without a command start");
  a_lock_block: assert property (launchWr && accessLock |=> !cmdStart_r)
    else $error("command started while locked");
  a_busy_ignore: assert property (
    launchWr && manualBusy_r |=> !cmdStart_r)
    else $error("second launch restarted a busy command");
  a_setup_len: assert property (
    $rose(cmdStart_r) |-> !macroPulse_r ##2 macroPulse_r)
    else $error("setup phase length wrong");
  a_pulse_len: assert property (
    $rose(macroPulse_r) |-> ##19 macroPulse_r ##1 !macroPulse_r)
    else $error("pulse phase length wrong");
  a_busy_tail: assert property (
    $fell(macroPulse_r) |-> manualBusy_r[*6] ##1 !manualBusy_r)
    else $error("busy does not end after hold and recovery");
  a_launch_zero: assert property (launchRd |=> regRdata_r == 16'h0000)
    else $error("launch register read nonzero");
  a_busy_read: assert property (
    statusRd |=> regRdata_r[7] == $past(manualBusy_r))
    else $error("status busy bit differs from busy output");
endmodule

bind otpm_manual_command_status otpm_manual_command_status_props #(
  .MonTickCycles(MonTickCycles)
) otpm_manual_command_status_props_inst (
  .clk(clk), .reset(reset), .regReq(regReq), .regRdata_r(regRdata_r),
  .macroPins(macroPins), .accessLock(accessLock), .events(events),
  .cmdStart_r(cmdStart_r), .macroPulse_r(macroPulse_r),
  .manualBusy_r(manualBusy_r)
);

// File: tb_otpm_manual_command_status.sv
// Self-checking bench for the manual command and status block.
// Assumes the macro model drives the pins; monitor tick shortened to 4.
`timescale 1ns/1ps
module tb_otpm_manual_command_status;
  import otpm_pkg::*;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  otpm_regreq_t regReq = '0;
  logic [15:0]  regRdata_r;
  otpm_pins_t   macroPins;
  logic         accessLock = 1'b0;
  otpm_events_t events = '0;
  logic         cmdStart_r;
  logic         macroPulse_r;
  logic         manualBusy_r;
  logic         statusReq = 1'b0;
  logic         pumpIdleReq = 1'b0;
  logic [15:0]  d;
  int           n_fail = 0;
  int           checked = 0;
  int           cyc = 0;
  int           starts = 0;
  always #25 clk = ~clk;

  otpm_manual_command_status #(.MonTickCycles(4))
    otpm_manual_command_status_inst (
    .clk(clk), .reset(reset), .regReq(regReq), .regRdata_r(regRdata_r),
    .macroPins(macroPins), .accessLock(accessLock), .events(events),
    .cmdStart_r(cmdStart_r), .macroPulse_r(macroPulse_r),
    .manualBusy_r(manualBusy_r));
  otpm_macro_model otpm_macro_model_inst (
    .clk(clk), .reset(reset), .statusReq(statusReq),
    .pumpIdleReq(pumpIdleReq), .macroPins(macroPins));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmdStart_r === 1'b1) starts <= starts + 1;
    if (cyc == 4000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk); #1;
    regReq.addr = a;
    regReq.wdata = v;
    regReq.wr = 1'b1;
    @(posedge clk); #1;
    regReq.wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk); #1;
    regReq.addr = a;
    regReq.rd = 1'b1;
    @(posedge clk); #1;
    regReq.rd = 1'b0;
    d = regRdata_r;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // start-up defaults
  task automatic t_startup();
    rd(LIMIT_OFS);
    chk(d, 16'h03d0);
    rd(EVENT_OFS);
    chk(d, 16'h0000);
    for (int i = 0; i < 50 && d[2:0] !== CODE_IDLE; i++) rd(STATUS_OFS);
    chk(d, 16'h0014);
  endtask
  task automatic t_launch();
    logic [14:0] seq;
    logic        busySeen;
    seq = '0;
    busySeen = 1'b0;
    wr(LAUNCH_OFS, 16'h0001);
    // Back-to-back reads so that two-cycle phases are not missed
    @(posedge clk); #1;
    regReq.addr = STATUS_OFS;
    regReq.rd = 1'b1;
    repeat (32) begin
      @(posedge clk); #1;
      if (regRdata_r[2:0] !== seq[2:0]) seq = {seq[11:0], regRdata_r[2:0]};
      if (regRdata_r[2:0] === CODE_PULSE) busySeen |= regRdata_r[7];
    end
    regReq.rd = 1'b0;
    chk({1'b0, seq}, {1'b0, CODE_SETUP, CODE_PULSE, CODE_HOLD,
        CODE_RECOVERY, CODE_IDLE});
    chk({15'h0, busySeen}, 16'h0001);
    rd(EVENT_OFS);
    chk(d, 16'h0080);
    rd(LAUNCH_OFS);
    chk(d, 16'h0000);
    wr(EVENT_OFS, 16'h007f);
    rd(EVENT_OFS);
    chk(d, 16'h0080);
    wr(EVENT_OFS, 16'h0080);
    rd(EVENT_OFS);
    chk(d, 16'h0000);
  endtask
  task automatic t_refuse();
    int s0;
    s0 = starts;
    accessLock = 1'b1;
    wr(LAUNCH_OFS, 16'h0001);
    idle(40);
    accessLock = 1'b0;
    rd(EVENT_OFS);
    chk(d, 16'h0000);
    chk(16'(starts - s0), 16'h0000);
    wr(LAUNCH_OFS, 16'h0001);
    wr(LAUNCH_OFS, 16'h0001);
    idle(40);
    chk(16'(starts - s0), 16'h0001);
    wr(EVENT_OFS, 16'h0080);
  endtask
  task automatic t_events();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk); #1;
      events = otpm_events_t'(4'(1 << i));
      @(posedge clk); #1;
      events = '0;
      rd(EVENT_OFS);
      chk(d, 16'(1 << i));
      wr(EVENT_OFS, 16'(1 << i));
      rd(EVENT_OFS);
      chk(d, 16'h0000);
    end
  endtask
  task automatic t_status();
    statusReq = 1'b1;
    pumpIdleReq = 1'b1;
    idle(6);
    rd(STATUS_OFS);
    chk(d, 16'h0074);
    wr(EVENT_OFS, 16'h0040);
    rd(EVENT_OFS);
    chk(d, 16'h0040);
    statusReq = 1'b0;
    pumpIdleReq = 1'b0;
    idle(6);
    rd(EVENT_OFS);
    chk(d, 16'h0040);
    wr(EVENT_OFS, 16'h0040);
    rd(STATUS_OFS);
    chk(d, 16'h0014);
  endtask
  task automatic t_pump();
    wr(LIMIT_OFS, 16'h0002);
    rd(LIMIT_OFS);
    chk(d, 16'h0002);
    pumpIdleReq = 1'b1;
    // Reads land one edge before and one edge after the error is due
    idle(14);
    rd(EVENT_OFS);
    chk(d, 16'h0000);
    rd(EVENT_OFS);
    chk(d, 16'h0020);
    wr(EVENT_OFS, 16'h0020);
    rd(EVENT_OFS);
    chk(d, 16'h0020);
    pumpIdleReq = 1'b0;
    idle(8);
    wr(EVENT_OFS, 16'h0020);
    rd(EVENT_OFS);
    chk(d, 16'h0000);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    t_startup();
    t_launch();
    t_refuse();
    t_events();
    t_status();
    t_pump();
    results();
  end
endmodule
